// ===== hw/vbc_pkg.sv
// Shared constants and types for the video buffer channel control link
package vbc_pkg;
   localparam int NUM_CH = 3;
   // Slave address and subaddress layout
   localparam logic [4:0] ADDR_PREFIX = 5'h0B;
   localparam logic [5:0] SUB_UPPER_ZERO = 6'h00;
   localparam logic [1:0] SUB_NONE = 2'h0;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic WR_DIR = 1'b0;
   localparam logic RD_DIR = 1'b1;
   // Channel register fields
   localparam int CLAMP_MSB = 7;
   localparam int CLAMP_LSB = 6;
   localparam int MUX_BIT = 5;
   localparam int LP_MSB = 4;
   localparam int LP_LSB = 3;
   localparam int BIAS_MSB = 2;
   localparam int BIAS_LSB = 0;
   localparam logic [7:0] RD_INVALID = 8'h00;
   // Controller registers on AHB-Lite
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam int CMD_GO = 0;
   localparam int CMD_READ = 1;
   localparam int CMD_ASEL_LSB = 2;
   localparam int CMD_SUB_LSB = 8;
   localparam int CMD_DATA_LSB = 16;
   localparam int STS_BUSY = 0;
   localparam int STS_NACK = 1;
   localparam int STS_RDATA_LSB = 8;
   localparam logic [31:0] CMD_RESET = 32'h0000_0000;
   // Link timing
   localparam int SYS_CLK_NS = 25;
   localparam int SCL_HALF_NS = 5000;
   localparam int SCL_HALF_CYC = (SCL_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam logic [7:0] HALF_TOP = 8'(SCL_HALF_CYC - 1);
   typedef enum logic [1:0] {VBC_CLAMP_NONE, VBC_CLAMP_500K, VBC_CLAMP_2M5, VBC_CLAMP_5M} vbc_clamp_e;
   typedef enum logic [1:0] {VBC_LP_9M, VBC_LP_16M, VBC_LP_35M, VBC_LP_BYPASS} vbc_lp_e;
   typedef enum logic [2:0] {VBC_BIAS_OFF, VBC_BIAS_MUTE, VBC_BIAS_DC, VBC_BIAS_DC_OFS, VBC_BIAS_AC,
                             VBC_BIAS_CLAMP_LO, VBC_BIAS_CLAMP_MID, VBC_BIAS_CLAMP_HI} vbc_bias_e;
   typedef enum {D_IDLE, D_ADDR, D_ADDR_ACK, D_SUB, D_SUB_ACK, D_DATA, D_DATA_ACK, D_RD, D_MACK,
                 D_SKIP} vbc_dev_st_e;
   typedef enum {H_IDLE, H_START, H_LO, H_HI, H_P1, H_P2, H_P3} vbc_host_st_e;
endpackage

// ===== hw/vbc_if.sv
// Two-wire link between controller and channel buffer
`timescale 1ns/1ps
interface vbc_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;
   // Wired AND with pull-ups; enables are active low
   assign scl = host_scl_oe_n ? 1'b1 : host_scl_o;
   assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o) & (dev_sda_oe_n ? 1'b1 : dev_sda_o);
   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o,
                 output host_sda_oe_n);
endinterface

// ===== hw/vbc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module vbc_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   // First stage feeds only the second
   always_ff @(posedge clk_i) begin
      meta <= d_i;
      q_o <= meta;
   end
endmodule // vbc_sync

// ===== hw/vbc_dev.sv
// Channel buffer end: two-wire slave with three channel registers
// Functional notes
// - Answer address of fixed prefix plus pins
// - Upper pin to bit 2, lower to 1
// - Address pins compared live, never latched
// - Write: address, subaddress, data, each acknowledged
// - Acknowledge subaddress after eight bits
// - One data byte only, no increment
// - Host writes each channel separately
// - Subaddress upper six bits zero
// - Subaddress 1 to 3 pick channels
// - All bytes shifted MSB first
// - Read phase one keeps selected subaddress
// - Read phase two returns one register byte
// - Host ends read with NACK, stop
// - Separate register per channel
// - Bits 7:6 select clamp filter
// - Clamp filter only in clamp modes
// - Bit 5 picks input A or B
// - Bits 4:3 select lowpass or bypass
// - Bits 2:0 select bias or disable
// - Registers unreset, random until written
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module vbc_dev (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   vbc_if.device link,
   input wire logic addr_select_hi_i,
   input wire logic addr_select_lo_i,
   output logic input_b_o [vbc_pkg::NUM_CH],
   output vbc_pkg::vbc_lp_e video_lowpass_o [vbc_pkg::NUM_CH],
   output vbc_pkg::vbc_bias_e bias_o [vbc_pkg::NUM_CH],
   output vbc_pkg::vbc_clamp_e sync_tip_clamp_o [vbc_pkg::NUM_CH]
);
   logic [3:0] pins;
   logic scl;
   logic sda;
   logic asel_hi;
   logic asel_lo;
   logic prev_scl;
   logic prev_sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   vbc_pkg::vbc_dev_st_e state;
   vbc_pkg::vbc_dev_st_e next_state;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [7:0] sh;
   logic [7:0] next_sh;
   logic drv;
   logic next_drv;
   logic rw;
   logic next_rw;
   logic [7:0] sub;
   logic [7:0] next_sub;
   logic wr_en;
   logic [7:0] rd_byte;
   logic [7:0] ch_cfg [vbc_pkg::NUM_CH];
   logic [7:0] next_ch_cfg [vbc_pkg::NUM_CH];

   function automatic logic ch_valid(input logic [7:0] s);
      ch_valid = (s[7:2] == vbc_pkg::SUB_UPPER_ZERO) && (s[1:0] != vbc_pkg::SUB_NONE);
   endfunction

   function automatic logic [1:0] ch_index(input logic [7:0] s);
      ch_index = s[1:0] - 2'h1;
   endfunction

   function automatic vbc_pkg::vbc_clamp_e clamp_of(input logic [7:0] c);
      vbc_pkg::vbc_bias_e b;
      b = vbc_pkg::vbc_bias_e'(c[vbc_pkg::BIAS_MSB:vbc_pkg::BIAS_LSB]);
      if (b < vbc_pkg::VBC_BIAS_CLAMP_LO) begin
         clamp_of = vbc_pkg::VBC_CLAMP_NONE;
      end else begin
         unique case (c[vbc_pkg::CLAMP_MSB:vbc_pkg::CLAMP_LSB])
            2'h0: clamp_of = vbc_pkg::VBC_CLAMP_500K;
            2'h1: clamp_of = vbc_pkg::VBC_CLAMP_2M5;
            2'h2: clamp_of = vbc_pkg::VBC_CLAMP_5M;
            2'h3: clamp_of = vbc_pkg::VBC_CLAMP_5M;
         endcase
      end
   endfunction

   vbc_sync #(
      .W(4)
   ) u_sync (
      .clk_i(sys_clk_i),
      .d_i({link.scl, link.sda, addr_select_hi_i, addr_select_lo_i}),
      .q_o(pins)
   );

   assign scl = pins[3];
   assign sda = pins[2];
   assign asel_hi = pins[1];
   assign asel_lo = pins[0];

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         prev_scl <= 1'b1;
         prev_sda <= 1'b1;
      end else begin
         prev_scl <= scl;
         prev_sda <= sda;
      end
   end

   assign scl_rise = scl & ~prev_scl;
   assign scl_fall = ~scl & prev_scl;
   assign start_det = prev_sda & ~sda & scl & prev_scl;
   assign stop_det = ~prev_sda & sda & scl & prev_scl;

   // Unknown channel reads back as zero
   assign rd_byte = ch_valid(sub) ? ch_cfg[ch_index(sub)] : vbc_pkg::RD_INVALID;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sh = sh;
      next_drv = drv;
      next_rw = rw;
      next_sub = sub;
      wr_en = 1'b0;
      if (stop_det) begin
         next_state = vbc_pkg::D_IDLE;
         next_drv = 1'b0;
      end else if (start_det) begin
         next_state = vbc_pkg::D_ADDR;
         next_cnt = 4'h0;
         next_drv = 1'b0;
      end else begin
         unique case (state)
            vbc_pkg::D_IDLE, vbc_pkg::D_SKIP: begin
               next_drv = 1'b0;
            end
            vbc_pkg::D_ADDR, vbc_pkg::D_SUB, vbc_pkg::D_DATA: begin
               if (scl_rise) begin
                  next_sh = {sh[6:0], sda};
                  next_cnt = cnt + 4'h1;
               end else if (scl_fall && cnt == vbc_pkg::BYTE_BITS) begin
                  next_cnt = 4'h0;
                  next_drv = 1'b1;
                  if (state == vbc_pkg::D_ADDR) begin
                     // Pins compared at every address byte, so a change takes effect at once
                     if (sh[7:1] == {vbc_pkg::ADDR_PREFIX, asel_hi, asel_lo}) begin
                        next_rw = sh[0];
                        next_state = vbc_pkg::D_ADDR_ACK;
                     end else begin
                        next_drv = 1'b0;
                        next_state = vbc_pkg::D_SKIP;
                     end
                  end else if (state == vbc_pkg::D_SUB) begin
                     next_sub = sh;
                     next_state = vbc_pkg::D_SUB_ACK;
                  end else begin
                     wr_en = 1'b1;
                     next_state = vbc_pkg::D_DATA_ACK;
                  end
               end
            end
            vbc_pkg::D_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rw == vbc_pkg::RD_DIR) begin
                     next_sh = rd_byte;
                     next_drv = ~rd_byte[7];
                     next_state = vbc_pkg::D_RD;
                  end else begin
                     next_drv = 1'b0;
                     next_state = vbc_pkg::D_SUB;
                  end
               end
            end
            vbc_pkg::D_SUB_ACK: begin
               if (scl_fall) begin
                  next_drv = 1'b0;
                  next_state = vbc_pkg::D_DATA;
               end
            end
            vbc_pkg::D_DATA_ACK: begin
               if (scl_fall) begin
                  // Later bytes are not taken nor acknowledged
                  next_drv = 1'b0;
                  next_state = vbc_pkg::D_SKIP;
               end
            end
            vbc_pkg::D_RD: begin
               if (scl_fall) begin
                  if (cnt == vbc_pkg::LAST_BIT) begin
                     next_drv = 1'b0;
                     next_state = vbc_pkg::D_MACK;
                  end else begin
                     next_sh = {sh[6:0], 1'b0};
                     next_drv = ~sh[6];
                     next_cnt = cnt + 4'h1;
                  end
               end
            end
            vbc_pkg::D_MACK: begin
               // Only one byte per read, whatever the master answers
               if (scl_rise) begin
                  next_state = vbc_pkg::D_SKIP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state <= vbc_pkg::D_IDLE;
         cnt <= 4'h0;
         sh <= 8'h00;
         drv <= 1'b0;
         rw <= 1'b0;
         sub <= 8'h00;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sh <= next_sh;
         drv <= next_drv;
         rw <= next_rw;
         sub <= next_sub;
      end
   end

   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe_n = ~drv;

   always_comb begin
      for (int i = 0; i < vbc_pkg::NUM_CH; i++) begin
         next_ch_cfg[i] = ch_cfg[i];
         if (wr_en && ch_valid(sub) && ch_index(sub) == 2'(i)) begin
            next_ch_cfg[i] = sh;
         end
      end
   end

   // No reset on purpose: contents are random until software writes them
   always_ff @(posedge sys_clk_i) begin
      ch_cfg <= next_ch_cfg;
   end

   for (genvar g = 0; g < vbc_pkg::NUM_CH; g++) begin : g_ch
      logic next_input_b;
      vbc_pkg::vbc_lp_e next_lp;
      vbc_pkg::vbc_bias_e next_bias;
      vbc_pkg::vbc_clamp_e next_clamp;
      always_comb begin
         next_input_b = ch_cfg[g][vbc_pkg::MUX_BIT];
         next_lp = vbc_pkg::vbc_lp_e'(ch_cfg[g][vbc_pkg::LP_MSB:vbc_pkg::LP_LSB]);
         next_bias = vbc_pkg::vbc_bias_e'(ch_cfg[g][vbc_pkg::BIAS_MSB:vbc_pkg::BIAS_LSB]);
         next_clamp = clamp_of(ch_cfg[g]);
      end
      always_ff @(posedge sys_clk_i) begin
         if (rst_i) begin
            input_b_o[g] <= 1'b0;
            video_lowpass_o[g] <= vbc_pkg::VBC_LP_9M;
            bias_o[g] <= vbc_pkg::VBC_BIAS_OFF;
            sync_tip_clamp_o[g] <= vbc_pkg::VBC_CLAMP_NONE;
         end else begin
            input_b_o[g] <= next_input_b;
            video_lowpass_o[g] <= next_lp;
            bias_o[g] <= next_bias;
            sync_tip_clamp_o[g] <= next_clamp;
         end
      end
   end
endmodule // vbc_dev

// ===== hw/vbc_host.sv
// Controller end: AHB-Lite registers driving the two-wire master
`timescale 1ns/1ps
module vbc_host (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   vbc_if.host link,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o
);
   logic [1:0] pins;
   logic sda;
   logic dp_wr;
   logic next_dp_wr;
   logic [7:0] dp_addr;
   logic [7:0] next_dp_addr;
   logic [31:0] next_hrdata;
   logic [31:0] cmd;
   logic [31:0] next_cmd;
   logic go;
   logic rw;
   vbc_pkg::vbc_host_st_e state;
   vbc_pkg::vbc_host_st_e next_state;
   logic [7:0] tcnt;
   logic [7:0] next_tcnt;
   logic tick;
   logic scl_low;
   logic next_scl_low;
   logic sda_low;
   logic next_sda_low;
   logic [1:0] step;
   logic [1:0] next_step;
   logic [3:0] bitn;
   logic [3:0] next_bitn;
   logic [7:0] sh;
   logic [7:0] next_sh;
   logic busy;
   logic next_busy;
   logic nack;
   logic next_nack;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic [7:0] nb;
   logic cont;

   // Step 0 address, 1 subaddress, 2 data or read address, 3 received byte
   function automatic logic [7:0] byte_of(input logic [1:0] s, input logic r, input logic [31:0] c);
      unique case (s)
         2'h0: byte_of = {vbc_pkg::ADDR_PREFIX, c[vbc_pkg::CMD_ASEL_LSB+:2], vbc_pkg::WR_DIR};
         2'h1: byte_of = c[vbc_pkg::CMD_SUB_LSB+:8];
         2'h2: byte_of = r ? {vbc_pkg::ADDR_PREFIX, c[vbc_pkg::CMD_ASEL_LSB+:2], vbc_pkg::RD_DIR}
                           : c[vbc_pkg::CMD_DATA_LSB+:8];
         2'h3: byte_of = 8'hFF;
      endcase
   endfunction

   vbc_sync #(
      .W(2)
   ) u_sync (
      .clk_i(sys_clk_i),
      .d_i({link.scl, link.sda}),
      .q_o(pins)
   );

   assign sda = pins[0];
   assign rw = cmd[vbc_pkg::CMD_READ];

   // Zero-wait slave; read data registered in the address phase
   always_comb begin
      next_dp_wr = hsel_i & hready_i & htrans_i[1] & hwrite_i;
      next_dp_addr = haddr_i[7:0];
      next_hrdata = hrdata_o;
      next_cmd = cmd;
      go = 1'b0;
      if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
         next_hrdata = 32'h0000_0000;
         if (haddr_i[7:0] == vbc_pkg::REG_CMD) begin
            next_hrdata = cmd;
         end else if (haddr_i[7:0] == vbc_pkg::REG_STATUS) begin
            next_hrdata[vbc_pkg::STS_BUSY] = busy;
            next_hrdata[vbc_pkg::STS_NACK] = nack;
            next_hrdata[vbc_pkg::STS_RDATA_LSB+:8] = rdata;
         end
      end
      if (dp_wr && dp_addr == vbc_pkg::REG_CMD && !busy) begin
         next_cmd = hwdata_i;
         next_cmd[vbc_pkg::CMD_GO] = 1'b0;
         go = hwdata_i[vbc_pkg::CMD_GO];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         dp_wr <= 1'b0;
         dp_addr <= 8'h00;
         hrdata_o <= 32'h0000_0000;
         cmd <= vbc_pkg::CMD_RESET;
      end else begin
         dp_wr <= next_dp_wr;
         dp_addr <= next_dp_addr;
         hrdata_o <= next_hrdata;
         cmd <= next_cmd;
      end
   end

   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign tick = (tcnt == vbc_pkg::HALF_TOP);
   assign nb = byte_of(step + 2'h1, rw, cmd);
   // Write ends after the data byte; only a read goes on past its second address byte
   assign cont = (step == 2'h0) || (step == 2'h1 && !rw) || (step == 2'h2 && rw);

   always_comb begin
      next_state = state;
      next_tcnt = (state == vbc_pkg::H_IDLE || tick) ? 8'h00 : tcnt + 8'h01;
      next_scl_low = scl_low;
      next_sda_low = sda_low;
      next_step = step;
      next_bitn = bitn;
      next_sh = sh;
      next_busy = busy;
      next_nack = nack;
      next_rdata = rdata;
      unique case (state)
         vbc_pkg::H_IDLE: begin
            if (go) begin
               next_busy = 1'b1;
               next_nack = 1'b0;
               next_step = 2'h0;
               next_sda_low = 1'b1;
               next_state = vbc_pkg::H_START;
            end
         end
         vbc_pkg::H_START: begin
            if (tick) begin
               next_scl_low = 1'b1;
               next_sh = byte_of(step, rw, cmd);
               next_bitn = 4'h0;
               next_sda_low = ~next_sh[7];
               next_state = vbc_pkg::H_LO;
            end
         end
         vbc_pkg::H_LO: begin
            if (tick) begin
               next_scl_low = 1'b0;
               next_state = vbc_pkg::H_HI;
            end
         end
         vbc_pkg::H_HI: begin
            if (tick) begin
               next_scl_low = 1'b1;
               next_state = vbc_pkg::H_LO;
               if (bitn != vbc_pkg::BYTE_BITS) begin
                  // One shift both sends and receives
                  next_sh = {sh[6:0], sda};
                  next_bitn = bitn + 4'h1;
                  next_sda_low = (step != 2'h3) && (bitn != vbc_pkg::LAST_BIT) && ~sh[6];
               end else if (step != 2'h3 && sda) begin
                  next_nack = 1'b1;
                  next_sda_low = 1'b1;
                  next_state = vbc_pkg::H_P1;
               end else if (cont) begin
                  next_step = step + 2'h1;
                  next_sh = nb;
                  next_bitn = 4'h0;
                  next_sda_low = (step != 2'h2) && ~nb[7];
               end else begin
                  if (step == 2'h3) begin
                     next_rdata = sh;
                  end
                  next_sda_low = 1'b1;
                  next_state = vbc_pkg::H_P1;
               end
            end
         end
         vbc_pkg::H_P1: begin
            if (tick) begin
               next_scl_low = 1'b0;
               next_state = vbc_pkg::H_P2;
            end
         end
         vbc_pkg::H_P2: begin
            if (tick) begin
               next_sda_low = 1'b0;
               next_state = vbc_pkg::H_P3;
            end
         end
         vbc_pkg::H_P3: begin
            if (tick) begin
               if (rw && step == 2'h1 && !nack) begin
                  next_step = 2'h2;
                  next_sda_low = 1'b1;
                  next_state = vbc_pkg::H_START;
               end else begin
                  next_busy = 1'b0;
                  next_state = vbc_pkg::H_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state <= vbc_pkg::H_IDLE;
         tcnt <= 8'h00;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         step <= 2'h0;
         bitn <= 4'h0;
         sh <= 8'h00;
         busy <= 1'b0;
         nack <= 1'b0;
         rdata <= 8'h00;
      end else begin
         state <= next_state;
         tcnt <= next_tcnt;
         scl_low <= next_scl_low;
         sda_low <= next_sda_low;
         step <= next_step;
         bitn <= next_bitn;
         sh <= next_sh;
         busy <= next_busy;
         nack <= next_nack;
         rdata <= next_rdata;
      end
   end

   // Open drain: only ever pulls low
   assign link.host_scl_o = 1'b0;
   assign link.host_scl_oe_n = ~scl_low;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe_n = ~sda_low;
endmodule // vbc_host

// ===== verification/vbc_chk_sva.sv
// Wire-level checker for the two-wire link between controller and channel buffer
`timescale 1ns/1ps
module vbc_chk (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic host_scl_o,
   input wire logic host_scl_oe_n,
   input wire logic host_sda_o,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic addr_select_hi_i,
   input wire logic addr_select_lo_i
);
   logic [5:0] cnt;
   logic [7:0] sh;
   logic rd;
   logic amatch;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Start or stop restarts the bit count
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || (scl && $changed(sda))) begin
         cnt <= 6'h00;
         rd <= 1'b0;
         amatch <= 1'b0;
      end else if ($rose(scl)) begin
         cnt <= cnt + 6'h01;
         sh <= {sh[6:0], sda};
         if (cnt == 6'h07) rd <= sda;
         if (cnt == 6'h08) amatch <= !sda;
      end
   end
   sequence s_slot(int n);
      $rose(scl) && cnt == n;
   endsequence
   sequence s_stop;
      scl && $rose(sda);
   endsequence
   property p_ack_addr;
      s_slot(8) |-> (!sda) == (sh[7:1] == {vbc_pkg::ADDR_PREFIX, addr_select_hi_i, addr_select_lo_i});
   endproperty
   a_ack_addr: assert property (p_ack_addr) else $error("address acknowledge wrong");
   property p_ack_sub;
      s_slot(17) ##0 (amatch && !rd) |-> !sda;
   endproperty
   a_ack_sub: assert property (p_ack_sub) else $error("subaddress not acknowledged");
   property p_ack_data;
      s_slot(26) ##0 (amatch && !rd) |-> !sda;
   endproperty
   a_ack_data: assert property (p_ack_data) else $error("data byte not acknowledged");
   property p_host_nack;
      s_slot(17) ##0 (amatch && rd) |-> sda;
   endproperty
   a_host_nack: assert property (p_host_nack) else $error("read byte acknowledged by host");
   property p_drive_slot;
      $rose(scl) && !dev_sda_oe_n |-> cnt == 8 || (rd ? (cnt >= 9 && cnt <= 16) : (cnt == 17 || cnt == 26));
   endproperty
   a_drive_slot: assert property (p_drive_slot) else $error("device drives outside its slots");
   property p_no_clash;
      scl && !dev_sda_oe_n |-> host_sda_oe_n;
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive data line");
   property p_dev_change;
      $changed(dev_sda_oe_n) |-> !scl;
   endproperty
   a_dev_change: assert property (p_dev_change) else $error("device changed data while clock high");
   property p_stop_after;
      $fell(scl) && cnt == 27 && !rd |-> ##[1:1000] s_stop;
   endproperty
   a_stop_after: assert property (p_stop_after) else $error("no stop after data byte");
endmodule // vbc_chk

// ===== verification/tb_video_buffer_i2c_channel_control.sv
// Bench: AHB-Lite controller driving the channel buffer over the two-wire link
`timescale 1ns/1ps
module tb_video_buffer_i2c_channel_control;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic [31:0] hrdata;
   logic asel_hi = 1'b1;
   logic asel_lo = 1'b0;
   logic input_b [vbc_pkg::NUM_CH];
   vbc_pkg::vbc_lp_e lp [vbc_pkg::NUM_CH];
   vbc_pkg::vbc_bias_e bias [vbc_pkg::NUM_CH];
   vbc_pkg::vbc_clamp_e clamp [vbc_pkg::NUM_CH];
   logic [7:0] e [3] = '{8'hF5, 8'h4E, 8'h3F};
   logic [31:0] s;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc = 0;
   vbc_if lnk();
   vbc_host u_vbc_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(lnk), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
      .hreadyout_o(hreadyout), .hresp_o(), .hrdata_o(hrdata));
   vbc_dev u_vbc_dev (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(lnk), .addr_select_hi_i(asel_hi),
      .addr_select_lo_i(asel_lo), .input_b_o(input_b), .video_lowpass_o(lp), .bias_o(bias), .sync_tip_clamp_o(clamp));
   vbc_chk u_vbc_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .host_scl_o(lnk.host_scl_o),
      .host_scl_oe_n(lnk.host_scl_oe_n), .host_sda_o(lnk.host_sda_o), .host_sda_oe_n(lnk.host_sda_oe_n),
      .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe_n(lnk.dev_sda_oe_n), .scl(lnk.scl), .sda(lnk.sda),
      .addr_select_hi_i(asel_hi), .addr_select_lo_i(asel_lo));
   always #12.5 sys_clk_i = ~sys_clk_i;
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Ceiling sits a quarter above five writes, one read and one refused address
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 98000) begin
         n_mismatch = n_mismatch + 1;
         print_verdict;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Leading edge keeps back-to-back calls from driving htrans twice at one edge
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk_i);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge sys_clk_i);
      while (hreadyout !== 1'b1) @(posedge sys_clk_i);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge sys_clk_i);
      while (hreadyout !== 1'b1) @(posedge sys_clk_i);
      rd = hrdata;
   endtask
   task run(input logic rdo, input logic [1:0] as, input logic [7:0] sub, input logic [7:0] dat);
      xfer(vbc_pkg::REG_CMD, 1'b1, {8'h00, dat, sub, 4'h0, as, rdo, 1'b1}, s);
      s = 32'h1;
      while (s[vbc_pkg::STS_BUSY] !== 1'b0) xfer(vbc_pkg::REG_STATUS, 1'b0, 32'h0, s);
   endtask
   task chk_ch(input int i, input logic [7:0] b);
      vbc_pkg::vbc_clamp_e c;
      c = (b[2:0] < 3'h5) ? vbc_pkg::VBC_CLAMP_NONE : (b[7:6] == 2'h0) ? vbc_pkg::VBC_CLAMP_500K :
         (b[7:6] == 2'h1) ? vbc_pkg::VBC_CLAMP_2M5 : vbc_pkg::VBC_CLAMP_5M;
      chk(input_b[i], b[5]);
      chk(lp[i], b[4:3]);
      chk(bias[i], b[2:0]);
      chk(clamp[i], c);
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // Power-up: every channel written before use
      for (int i = 0; i < 3; i++) begin
         run(1'b0, 2'h2, 8'(i + 1), e[i]);
         chk(s[vbc_pkg::STS_NACK], 1'b0);
      end
      for (int i = 0; i < 3; i++) chk_ch(i, e[i]);
      $display("test write_all done");
      run(1'b0, 2'h2, 8'h05, 8'h00);
      for (int i = 0; i < 3; i++) chk_ch(i, e[i]);
      $display("test bad_sub done");
      run(1'b1, 2'h2, 8'h02, 8'h00);
      chk(s[15:8], e[1]);
      chk(s[vbc_pkg::STS_NACK], 1'b0);
      $display("test read done");
      run(1'b0, 2'h1, 8'h01, 8'h00);
      chk(s[vbc_pkg::STS_NACK], 1'b1);
      chk_ch(0, e[0]);
      $display("test wrong_addr done");
      // Pins move at run time; the same address must now be answered
      asel_hi <= 1'b0;
      asel_lo <= 1'b1;
      e[0] = 8'hC3;
      run(1'b0, 2'h1, 8'h01, e[0]);
      chk(s[vbc_pkg::STS_NACK], 1'b0);
      for (int i = 0; i < 3; i++) chk_ch(i, e[i]);
      $display("test live_pins done");
      print_verdict;
   end
endmodule // tb_video_buffer_i2c_channel_control
